// File: design/rcu_defs.svh
// constants of the redundant command uplink: widths, addresses, timing
// assumes inclusion by bare name from the package and the design files
`ifndef RCU_DEFS_SVH
`define RCU_DEFS_SVH

// ***************************************
// word layout
// ***************************************
`define RCU_WORD_W 24
`define RCU_ADDR_W 6
`define RCU_DATA_W 18
`define RCU_SER_W 48
`define RCU_HALF_W 24
`define RCU_CNT_W 6

// ***************************************
// destination addresses
// ***************************************
`define RCU_ADDR_SEQ 6'h01
`define RCU_ADDR_PWR 6'h02
`define RCU_ADDR_LCE 6'h03
`define RCU_ADDR_LINK 6'h3F

// ***************************************
// channels and link discretes
// ***************************************
`define RCU_NCH 4
`define RCU_CH_W 2
`define RCU_NDISC 8
`define RCU_DISC_IDX_W 3
`define RCU_DISC_VAL_BIT 4

// ***************************************
// timing
// ***************************************
`define RCU_CLK_MHZ 250
`define RCU_BIT_NS 400
`define RCU_BIT_CYCLES ((`RCU_BIT_NS * `RCU_CLK_MHZ) / 1000)
`define RCU_DIV_W 8

`endif

// File: design/rcu_pkg.sv
// types of the redundant command uplink
// assumes rcu_defs.svh is on the include path
package rcu_pkg;
  `include "rcu_defs.svh"

  // ***************************************
  // command word
  // ***************************************
  typedef struct packed {
    logic [`RCU_ADDR_W-1:0] addr;
    logic [`RCU_DATA_W-1:0] data;
  } rcu_cmd_t;

  typedef enum logic [0:0] {RCU_TX_IDLE, RCU_TX_SEND} rcu_tx_st_t;

  // ***************************************
  // transmitter state
  // ***************************************
  typedef struct packed {
    rcu_tx_st_t st;
    rcu_cmd_t word;
    logic [`RCU_SER_W-1:0] sr;
    logic [`RCU_CNT_W-1:0] cnt;
    logic [`RCU_DIV_W-1:0] div;
    logic [`RCU_CH_W-1:0] ch;
    logic [`RCU_NCH-1:0] line_d;
    logic [`RCU_NCH-1:0] line_s;
    logic [`RCU_NCH-1:0] line_f;
  } rcu_tx_state_t;

  // ***************************************
  // receive checker state
  // ***************************************
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic strobe_d;
    logic frame_d;
    logic [`RCU_SER_W-1:0] sr;
    logic [`RCU_CNT_W-1:0] cnt;
    logic ok;
    logic err;
    rcu_cmd_t word;
  } rcu_rx_state_t;

  // ***************************************
  // decoder state
  // ***************************************
  typedef struct packed {
    logic seq_v;
    logic pwr_v;
    logic lce_v;
    logic [`RCU_DATA_W-1:0] data;
    logic [`RCU_NDISC-1:0] disc;
    logic rep_v;
    rcu_cmd_t rep;
    logic addr_err;
  } rcu_dec_state_t;

  // ***************************************
  // uplink state: transmitter and decoder in one register
  // ***************************************
  typedef struct packed {
    rcu_tx_state_t tx;
    rcu_dec_state_t dec;
  } rcu_up_state_t;
endpackage

// File: design/rcu_rx_check.sv
// receive checker: synchronises the cable line, rebuilds the double word
// and compares the two copies; line pins are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "rcu_defs.svh"
module rcu_rx_check (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_data,
  input wire logic rx_strobe,
  input wire logic rx_frame,
  output logic word_ok,
  output rcu_pkg::rcu_cmd_t word,
  output logic word_err
);
  import rcu_pkg::*;

  rcu_rx_state_t s;
  rcu_rx_state_t next_s;
  logic strobe_rise;
  logic frame_fall;
  logic copies_match;

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    next_s = s;
    next_s.sync1 = {rx_data, rx_strobe, rx_frame};
    next_s.sync2 = s.sync1;
    next_s.strobe_d = s.sync2[1];
    next_s.frame_d = s.sync2[0];
    next_s.ok = 1'b0;
    next_s.err = 1'b0;
    if (strobe_rise && s.sync2[0]) begin
      next_s.sr = {s.sr[`RCU_SER_W-2:0], s.sync2[2]};
      // saturate so an overlong frame cannot wrap back to a valid count
      if (s.cnt != {`RCU_CNT_W{1'b1}}) begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
    if (frame_fall) begin
      next_s.cnt = '0;
      if (s.cnt == `RCU_CNT_W'(`RCU_SER_W) && copies_match) begin
        next_s.ok = 1'b1;
        next_s.word = s.sr[`RCU_HALF_W-1:0];
      end else begin
        next_s.err = 1'b1; // mismatch, short or overlong word dropped
      end
    end
  end

  assign strobe_rise = s.sync2[1] && !s.strobe_d;
  assign frame_fall = !s.sync2[0] && s.frame_d;
  assign copies_match =
    s.sr[`RCU_SER_W-1:`RCU_HALF_W] == s.sr[`RCU_HALF_W-1:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign word_ok = s.ok;
  assign word_err = s.err;
  assign word = s.word;

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_rx_good_copies: assert property (
    frame_fall && s.cnt == 6'd48 && copies_match |=> word_ok && !word_err)
    else $error("matching copies not accepted");
  a_rx_bad_copies: assert property (
    frame_fall && !copies_match |=> word_err && !word_ok)
    else $error("mismatched copies not flagged");
  a_rx_only_checked: assert property (
    word_ok |-> $past(frame_fall) && $past(s.cnt) == 6'd48)
    else $error("word passed without a full check");
  c_rx_ok: cover property (word_ok);
  c_rx_err: cover property (word_err);
endmodule
`default_nettype wire

// File: design/rcu_uplink.sv
// redundant command uplink: transmit terminal, receive checker, decoder
// assumes a command source on clk and cable line pins asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "rcu_defs.svh"

module rcu_uplink #(
  parameter int BIT_CYCLES = `RCU_BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire rcu_pkg::rcu_cmd_t cmd_word,
  input wire logic [`RCU_CH_W-1:0] cmd_chan,
  output logic cmd_ready,
  output logic [`RCU_NCH-1:0] tx_data,
  output logic [`RCU_NCH-1:0] tx_strobe,
  output logic [`RCU_NCH-1:0] tx_frame,
  input wire logic rx_data,
  input wire logic rx_strobe,
  input wire logic rx_frame,
  output logic seq_valid,
  output logic power_valid,
  output logic launch_valid,
  output logic [`RCU_DATA_W-1:0] dest_data,
  output logic [`RCU_NDISC-1:0] link_discrete,
  output logic report_valid,
  output rcu_pkg::rcu_cmd_t report_word,
  output logic check_error,
  output logic addr_error
);
  import rcu_pkg::*;

  localparam logic [`RCU_DIV_W-1:0] DIV_LAST = `RCU_DIV_W'(BIT_CYCLES - 1);
  localparam logic [`RCU_DIV_W-1:0] DIV_HALF = `RCU_DIV_W'(BIT_CYCLES / 2);

  rcu_up_state_t s;
  rcu_up_state_t next_s;
  rcu_tx_state_t t;
  rcu_tx_state_t next_t;
  rcu_dec_state_t d;
  rcu_dec_state_t next_d;
  logic rx_ok;
  logic rx_err;
  rcu_cmd_t rx_word;

  // named views of the two halves of the state
  assign t = s.tx;
  assign d = s.dec;

  // one-hot lane mask for a channel number
  function automatic logic [`RCU_NCH-1:0] lane(
    input logic [`RCU_CH_W-1:0] ch
  );
    lane = `RCU_NCH'(1) << ch;
  endfunction

  // ***************************************
  // transmit terminal
  // ***************************************
  // data changes at bit start, strobe rises mid bit so the far end
  // samples a settled level; frame brackets all 48 bits
  always_comb begin
    next_t = t;
    case (t.st)
      RCU_TX_IDLE: begin
        if (cmd_valid) begin
          next_t.word = cmd_word;
          next_t.sr = {cmd_word, cmd_word};
          next_t.ch = cmd_chan;
          next_t.cnt = '0;
          next_t.div = '0;
          next_t.line_f = lane(cmd_chan);
          next_t.line_d = cmd_word[`RCU_WORD_W-1] ? lane(cmd_chan) : '0;
          next_t.line_s = '0;
          next_t.st = RCU_TX_SEND;
        end
      end
      RCU_TX_SEND: begin
        next_t.div = t.div + 1'b1;
        if (t.div == DIV_HALF) begin
          next_t.line_s = lane(t.ch);
        end
        if (t.div == DIV_LAST) begin
          next_t.div = '0;
          next_t.line_s = '0;
          next_t.sr = {t.sr[`RCU_SER_W-2:0], 1'b0};
          next_t.cnt = t.cnt + 1'b1;
          next_t.line_d = t.sr[`RCU_SER_W-2] ? lane(t.ch) : '0;
          if (t.cnt == `RCU_CNT_W'(`RCU_SER_W - 1)) begin
            next_t.line_f = '0;
            next_t.line_d = '0;
            next_t.st = RCU_TX_IDLE;
          end
        end
      end
      default: begin
        next_t.st = RCU_TX_IDLE;
      end
    endcase
    // decoder: only words that passed the copy compare reach this point,
    // so a corrupted address can never select a group
    next_d = d;
    next_d.seq_v = 1'b0;
    next_d.pwr_v = 1'b0;
    next_d.lce_v = 1'b0;
    next_d.rep_v = 1'b0;
    next_d.addr_err = 1'b0;
    if (rx_ok) begin
      next_d.data = rx_word.data; // address/data split
      next_d.rep = rx_word;
      next_d.rep_v = 1'b1;
      case (rx_word.addr)
        `RCU_ADDR_SEQ: begin
          next_d.seq_v = 1'b1;
        end
        `RCU_ADDR_PWR: begin
          next_d.pwr_v = 1'b1;
        end
        `RCU_ADDR_LCE: begin
          next_d.lce_v = 1'b1;
        end
        `RCU_ADDR_LINK: begin
          next_d.disc[rx_word.data[`RCU_DISC_IDX_W-1:0]] =
            rx_word.data[`RCU_DISC_VAL_BIT];
        end
        default: begin
          next_d.rep_v = 1'b0; // nothing executed, nothing reported
          next_d.addr_err = 1'b1;
        end
      endcase
    end
    next_s.tx = next_t;
    next_s.dec = next_d;
  end

  // one register for transmitter and decoder state, so the two halves never skew
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ready is combinational so a word is taken in the cycle it is offered
  assign cmd_ready = (t.st == RCU_TX_IDLE);
  assign tx_data = t.line_d;
  assign tx_strobe = t.line_s;
  assign tx_frame = t.line_f;

  // ***************************************
  // receive terminal
  // ***************************************
  rcu_rx_check u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .rx_data(rx_data),
    .rx_strobe(rx_strobe),
    .rx_frame(rx_frame),
    .word_ok(rx_ok),
    .word(rx_word),
    .word_err(rx_err)
  );

  // ***************************************
  // command decoder
  // ***************************************
  // decoder outputs come straight from the state register; check_error comes from the receive checker's register

  assign seq_valid = d.seq_v;
  assign power_valid = d.pwr_v;
  assign launch_valid = d.lce_v;
  assign dest_data = d.data;
  assign link_discrete = d.disc;
  assign report_valid = d.rep_v;
  assign report_word = d.rep;
  assign check_error = rx_err;
  assign addr_error = d.addr_err;

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_tx_busy_refuses: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready [*8])
    else $error("transmitter took a word while busy");
  a_tx_chan_steer: assert property (
    cmd_valid && cmd_ready |=> tx_frame == lane($past(cmd_chan)))
    else $error("frame not on selected channel");
  a_tx_one_chan: assert property (
    $onehot0(tx_frame) && $onehot0(tx_strobe))
    else $error("more than one channel driven");
  a_tx_second_copy: assert property (
    t.st == RCU_TX_SEND && t.cnt == 6'd24 |->
      t.sr[`RCU_SER_W-1:`RCU_HALF_W] == t.word)
    else $error("second copy differs from word");
  a_tx_frame_end: assert property (
    t.st == RCU_TX_SEND && t.cnt == 6'd47 && t.div == DIV_LAST |=>
      tx_frame == '0 && cmd_ready)
    else $error("frame not closed after 48 bits");
  a_dec_one_dest: assert property (
    $onehot0({seq_valid, power_valid, launch_valid}))
    else $error("command sent to two groups");
  a_dec_err_drop: assert property (
    rx_err |=> !(seq_valid || power_valid || launch_valid || report_valid))
    else $error("errored word forwarded");
  a_dec_report: assert property (
    rx_ok && rx_word.addr != 6'h00 && rx_word.addr != 6'h3E |=>
      report_valid == !addr_error && report_word == $past(rx_word))
    else $error("executed command not reported");
  a_dec_link_disc: assert property (
    rx_ok && rx_word.addr == `RCU_ADDR_LINK |=>
      link_discrete[$past(rx_word.data[2:0])] == $past(rx_word.data[4]))
    else $error("link discrete not updated");
  a_dec_seq_route: assert property (
    seq_valid |-> $past(rx_ok) && $past(rx_word.addr) == `RCU_ADDR_SEQ)
    else $error("unverified command reached sequencer");

  c_tx_word: cover property (cmd_valid && cmd_ready);
  c_dec_seq: cover property (seq_valid);
  c_dec_link: cover property (rx_ok && rx_word.addr == `RCU_ADDR_LINK);
endmodule
`default_nettype wire

// File: bench/rcu_cable_model.sv
// cable line model: sends one framed serial word onto the receive pins
// assumes the bench raises start for one cycle, just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module rcu_cable_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [47:0] bits,
  input wire logic [5:0] nbits,
  output logic line_data,
  output logic line_strobe,
  output logic line_frame
);
  int i;

  // ***************************************
  // framed bit sender
  // ***************************************
  // two cycles low, two high per bit: half the rate of the one low, one high that the receiver allows
  initial begin
    line_data = 1'b0;
    line_strobe = 1'b0;
    line_frame = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        #1 line_frame = 1'b1;
        for (i = 0; i < nbits; i++) begin
          line_data = bits[47-i]; // msb first, copy one then copy two
          repeat (2) @(posedge clk);
          #1 line_strobe = 1'b1;
          repeat (2) @(posedge clk);
          #1 line_strobe = 1'b0;
        end
        repeat (2) @(posedge clk);
        #1 line_frame = 1'b0;
      end else begin
        // idle data toggles, so a stale bit is never taken for a real one
        #1 line_data = ~line_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/rcu_uplink_tb_top.sv
// testbench of the redundant command uplink, transmit and receive paths
// assumes the design files and rcu_defs.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "rcu_defs.svh"
module rcu_uplink_tb_top;
  import rcu_pkg::*;
  logic clk, rst_b, cmd_valid, cmd_ready, rx_data, rx_strobe, rx_frame;
  rcu_cmd_t cmd_word, report_word;
  logic [1:0] cmd_chan;
  logic [3:0] tx_data, tx_strobe, tx_frame;
  logic seq_valid, power_valid, launch_valid, report_valid;
  logic check_error, addr_error, start;
  logic [17:0] dest_data;
  logic [7:0] link_discrete;
  logic [47:0] bits;
  logic [5:0] nbits;
  int mismatches, comparisons;

  // ***************************************
  // design and cable model
  // ***************************************
  // short bit time keeps each frame near 200 cycles
  rcu_uplink #(.BIT_CYCLES(4)) dut (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_chan(cmd_chan),
    .cmd_ready(cmd_ready), .tx_data(tx_data), .tx_strobe(tx_strobe),
    .tx_frame(tx_frame), .rx_data(rx_data), .rx_strobe(rx_strobe),
    .rx_frame(rx_frame), .seq_valid(seq_valid), .power_valid(power_valid),
    .launch_valid(launch_valid), .dest_data(dest_data),
    .link_discrete(link_discrete), .report_valid(report_valid),
    .report_word(report_word), .check_error(check_error),
    .addr_error(addr_error));
  rcu_cable_model cable (.clk(clk), .start(start), .bits(bits),
    .nbits(nbits), .line_data(rx_data), .line_strobe(rx_strobe),
    .line_frame(rx_frame));

  // ***************************************
  // helpers
  // ***************************************
  always #2 clk = ~clk;

  task tick;
    @(posedge clk);
    #1;
  endtask

  task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one word out on a lane; a second offer mid frame must be ignored
  task tx_word(input rcu_cmd_t w, input logic [1:0] ch);
    logic [47:0] got;
    int i, n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    cmd_word = w;
    cmd_chan = ch;
    cmd_valid = 1'b1;
    tick;
    cmd_valid = 1'b0;
    chk("tx frame lane", 4'h1 << ch, tx_frame);
    for (i = 0; i < 48; i++) begin
      n = 0;
      while (tx_strobe[ch] === 1'b1 && n < 20) begin
        tick;
        n++;
      end
      while (tx_strobe[ch] !== 1'b1 && n < 40) begin
        tick;
        n++;
      end
      got = {got[46:0], tx_data[ch]};
      chk("tx other lanes", 48'h0, tx_data & ~(4'h1 << ch));
      cmd_word = ~w;
      cmd_valid = (i == 10);
    end
    chk("tx double word", {w, w}, got);
    repeat (8) tick;
    chk("tx idle", 5'h10, {cmd_ready, tx_frame});
  endtask

  // one frame in; counts pulses of seq,pwr,lce,report,check,addr
  task rx_word(input rcu_cmd_t c1, input rcu_cmd_t c2, input logic [5:0] nb,
               input logic [11:0] exp);
    int cnt[6];
    int i;
    cnt = '{0, 0, 0, 0, 0, 0};
    bits = {c1, c2};
    nbits = nb;
    start = 1'b1;
    tick;
    start = 1'b0;
    for (i = 0; i < 230; i++) begin
      tick;
      cnt[0] += seq_valid;
      cnt[1] += power_valid;
      cnt[2] += launch_valid;
      cnt[3] += report_valid;
      cnt[4] += check_error;
      cnt[5] += addr_error;
    end
    chk("rx pulses", exp, {cnt[0][1:0], cnt[1][1:0], cnt[2][1:0],
      cnt[3][1:0], cnt[4][1:0], cnt[5][1:0]});
  endtask

  // ***************************************
  // scenarios
  // ***************************************
  task t_tx;
    int c;
    for (c = 0; c < 4; c++) begin
      tx_word({6'h01 + c[5:0], 18'h2A5C3 ^ c[17:0]}, c[1:0]);
    end
    $display("test tx done");
  endtask

  task t_groups;
    logic [5:0] ad[3];
    logic [11:0] ex[3];
    rcu_cmd_t w;
    int k;
    ad = '{`RCU_ADDR_SEQ, `RCU_ADDR_PWR, `RCU_ADDR_LCE};
    ex = '{12'h410, 12'h110, 12'h050};
    for (k = 0; k < 3; k++) begin
      // data field kept at 18 bits so the address stays in place
      w = {ad[k], 18'h1B2C0 + k[17:0]};
      rx_word(w, w, 48, ex[k]);
      chk("dest data", 18'h1B2C0 + k[17:0], dest_data);
      chk("report word", w, report_word);
    end
    $display("test groups done");
  endtask

  task t_link;
    rx_word({6'h3F, 18'h00015}, {6'h3F, 18'h00015}, 48, 12'h010);
    chk("discrete on", 8'h20, link_discrete);
    chk("link report", {6'h3F, 18'h00015}, report_word);
    rx_word({6'h3F, 18'h00005}, {6'h3F, 18'h00005}, 48, 12'h010);
    chk("discrete off", 8'h00, link_discrete);
    $display("test link done");
  endtask

  task t_bad;
    rx_word({6'h01, 18'h0F0F0}, {6'h01, 18'h0F0F1}, 48, 12'h004);
    rx_word({6'h02, 18'h00001}, {6'h02, 18'h00001}, 47, 12'h004);
    chk("dest kept", 18'h00005, dest_data); // last good: link word
    rx_word({6'h10, 18'h3FFFF}, {6'h10, 18'h3FFFF}, 48, 12'h001);
    $display("test bad words done");
  endtask

  // ***************************************
  // main sequence and watchdog
  // ***************************************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = '0;
    cmd_chan = 2'h0;
    start = 1'b0;
    bits = '0;
    nbits = 6'h30;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    tick;
    t_tx;
    t_groups;
    t_link;
    t_bad;
    finish_test;
  end

  // the run needs about 3000 cycles; the limit is ten times that
  initial begin
    #120000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
